// *** logic/scc_cmd_interp.sv ***
// serial configuration command interpreter with indicator control
`timescale 1ns/10ps
`include "scc_regs.svh"

module scc_cmd_interp
   import scc_pkg::*;
#(
   parameter int unsigned TMO_CYC    = `SCC_TMO_CYC,
   parameter int unsigned BEEP_CYC   = `SCC_BEEP_CYC,
   parameter int unsigned LONG_CYC   = `SCC_LONG_CYC,
   parameter int unsigned GAP_CYC    = `SCC_GAP_CYC,
   parameter int unsigned BLINK_CYC  = `SCC_BLINK_CYC,
   parameter int unsigned FLASH_CYC  = `SCC_FLASH_CYC,
   parameter int unsigned FIFO_DEPTH = 8
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // received bytes from the uart
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_valid,
   output logic             rx_ready,
   // reply bytes to the uart
   output logic [7:0]       tx_data,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   // accepted configuration command
   output logic [23:0]      cfg_code,
   output logic [2:0]       cfg_len,
   output logic             cfg_valid,
   output logic             cfg_defaults,
   // pending serial format from configuration store
   input  wire logic        fmt_wr,
   input  wire logic [16:0] fmt_baud_in,
   input  wire logic [2:0]  fmt_par_in,
   input  wire logic [1:0]  fmt_stop_in,
   input  wire logic [3:0]  fmt_data_in,
   // active serial format
   output logic [16:0]      ser_baud,
   output logic [2:0]       ser_par,
   output logic [1:0]       ser_stop,
   output logic [3:0]       ser_data,
   // scan engine
   input  wire logic        scan_req,
   input  wire logic        laser_on,
   input  wire logic        decode_ok,
   input  wire logic        host_busy,
   output logic             scan_run,
   output logic             decode_en,
   output logic             prog_mode,
   // power-up self-test
   input  wire logic        st_done,
   input  wire logic        st_fail_mem,
   input  wire logic        st_fail_laser,
   input  wire logic        st_fail_motor,
   input  wire logic        st_fail_elec,
   // indicators
   output logic             led_green,
   output logic             led_red,
   output logic             tone_on,
   output logic             tone_razz
);
   scc_state_e  state_r;
   scc_fault_e  fault_r;
   scc_tone_e   tone_kind_r;
   scc_tone_e   go_kind;
   logic [7:0]  q_data;
   logic        q_valid;
   logic        q_pop;
   logic [23:0] code_r;
   logic [2:0]  len_r;
   logic        bad_r;
   logic        prog_r;
   logic        frame_end;
   logic        frame_ok;
   logic        is_prog;
   logic        tmo_hit;
   logic [31:0] tmo_r;
   logic [16:0] pend_baud_r;
   logic [2:0]  pend_par_r;
   logic [1:0]  pend_stop_r;
   logic [3:0]  pend_data_r;
   logic        ev_enter;
   logic        ev_exit;
   logic        ev_reject;
   logic        ev_decode;
   logic        tone_go;
   logic [2:0]  go_n;
   logic [2:0]  tone_left_r;
   logic [31:0] tone_tmr_r;
   logic        tone_ph_r;
   logic        tone_cont_r;
   logic [31:0] blink_cnt_r;
   logic        blink_r;
   logic [31:0] flash_r;

   // sounding time of one tone of a kind
   function automatic logic [31:0] tone_len(input scc_tone_e k);
      tone_len = (k == SCC_TN_LONG) ? LONG_CYC : BEEP_CYC;
   endfunction : tone_len

   // =====================================================================
   // receive fifo, drained only while no reply waits
   scc_rx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .in_data   (rx_data),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .out_data  (q_data),
      .out_valid (q_valid),
      .out_ready (!tx_valid)
   );
   assign q_pop = q_valid & !tx_valid;

   // =====================================================================
   // frame decode
   assign frame_end = q_pop && state_r == SCC_BODY && q_data == `SCC_ETX;
   assign frame_ok  = !bad_r && len_r != 3'h0;
   assign is_prog   = len_r == 3'(`SCC_MAX_DIG) &&
                      code_r == `SCC_CODE_PROG;
   assign tmo_hit   = prog_r && tmo_r == 32'h0 && !frame_end && !tx_valid;

   // frame assembly: hunt for start, gather digits
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r <= SCC_HUNT;
         code_r  <= 24'h000000;
         len_r   <= 3'h0;
         bad_r   <= 1'b0;
      end else if (q_pop) begin
         if (q_data == `SCC_STX) begin
            state_r <= SCC_BODY;
            code_r  <= 24'h000000;
            len_r   <= 3'h0;
            bad_r   <= 1'b0;
         end else if (state_r == SCC_BODY) begin
            if (q_data == `SCC_ETX) begin
               state_r <= SCC_HUNT;
            end else if (q_data >= `SCC_DIG_LO &&
                         q_data <= `SCC_DIG_HI &&
                         len_r < 3'(`SCC_MAX_DIG)) begin
               code_r <= {code_r[19:0], q_data[3:0]};
               len_r  <= len_r + 3'h1;
            end else begin
               bad_r <= 1'b1;
            end
         end
      end
   end

   // =====================================================================
   // reply byte, held until the uart takes it
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tx_valid <= 1'b0;
         tx_data  <= 8'h00;
      end else if (frame_end) begin
         tx_valid <= 1'b1;
         if (frame_ok && (is_prog || prog_r)) begin
            tx_data <= `SCC_ACK;
         end else begin
            tx_data <= `SCC_NAK;
         end
      end else if (tmo_hit) begin
         tx_valid <= 1'b1;
         tx_data  <= `SCC_NAK;
      end else if (tx_ready) begin
         tx_valid <= 1'b0;
      end
   end

   // program mode events
   assign ev_enter  = frame_end && frame_ok && is_prog && !prog_r;
   assign ev_exit   = frame_end && frame_ok && is_prog && prog_r;
   assign ev_reject = prog_r && ((frame_end && !frame_ok) || tmo_hit);

   // program mode flag; a reject drops it so a resend is refused
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prog_r <= 1'b0;
      end else if (ev_enter) begin
         prog_r <= 1'b1;
      end else if (ev_exit) begin
         prog_r <= 1'b0;
      end else if (ev_reject) begin
         prog_r <= 1'b0;
      end
   end

   // inter-command timer, reloaded on each frame
   always_ff @(posedge clk_sys) begin
      if (srst || !prog_r || frame_end) begin
         tmo_r <= TMO_CYC - 1;
      end else if (tmo_r != 32'h0) begin
         tmo_r <= tmo_r - 32'h1;
      end
   end

   // accepted command strobes
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfg_valid    <= 1'b0;
         cfg_defaults <= 1'b0;
         cfg_code     <= 24'h000000;
         cfg_len      <= 3'h0;
      end else begin
         cfg_valid    <= frame_end && frame_ok && prog_r && !is_prog;
         cfg_defaults <= frame_end && frame_ok && prog_r &&
                         len_r == 3'(`SCC_MAX_DIG) &&
                         code_r == `SCC_CODE_DEFL;
         if (frame_end) begin
            cfg_code <= code_r;
            cfg_len  <= len_r;
         end
      end
   end

   // =====================================================================
   // pending and active serial format
   always_ff @(posedge clk_sys) begin
      if (srst || ev_enter) begin
         pend_baud_r <= srst ? `SCC_DEF_BAUD : ser_baud;
         pend_par_r  <= srst ? `SCC_DEF_PAR : ser_par;
         pend_stop_r <= srst ? `SCC_DEF_STOP : ser_stop;
         pend_data_r <= srst ? `SCC_DEF_DATA : ser_data;
      end else if (cfg_defaults) begin
         pend_baud_r <= `SCC_DEF_BAUD;
         pend_par_r  <= `SCC_DEF_PAR;
         pend_stop_r <= `SCC_DEF_STOP;
         pend_data_r <= `SCC_DEF_DATA;
      end else if (fmt_wr && prog_r) begin
         pend_baud_r <= fmt_baud_in;
         pend_par_r  <= fmt_par_in;
         pend_stop_r <= fmt_stop_in;
         pend_data_r <= fmt_data_in;
      end
   end

   // active format changes only on a clean exit
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ser_baud <= `SCC_DEF_BAUD;
         ser_par  <= `SCC_DEF_PAR;
         ser_stop <= `SCC_DEF_STOP;
         ser_data <= `SCC_DEF_DATA;
      end else if (ev_exit) begin
         ser_baud <= pend_baud_r;
         ser_par  <= pend_par_r;
         ser_stop <= pend_stop_r;
         ser_data <= pend_data_r;
      end
   end

   // scan engine control
   assign prog_mode = prog_r;
   assign scan_run  = scan_req | prog_r;
   assign decode_en = !prog_r;
   assign ev_decode = decode_ok & decode_en;

   // =====================================================================
   // self-test outcome, worst fault wins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fault_r <= SCC_FLT_NONE;
      end else if (st_done) begin
         if (st_fail_elec) begin
            fault_r <= SCC_FLT_ELEC;
         end else if (st_fail_motor) begin
            fault_r <= SCC_FLT_MOTOR;
         end else if (st_fail_laser) begin
            fault_r <= SCC_FLT_LASER;
         end else if (st_fail_mem) begin
            fault_r <= SCC_FLT_MEM;
         end else begin
            fault_r <= SCC_FLT_NONE;
         end
      end
   end

   // tone requests by cause
   always_comb begin
      tone_go = 1'b1;
      go_n    = 3'h1;
      go_kind = SCC_TN_BEEP;
      if (st_done && !st_fail_elec && st_fail_motor) begin
         go_n    = 3'h2;
         go_kind = SCC_TN_RAZZ;
      end else if (st_done && !st_fail_elec && st_fail_laser) begin
         go_kind = SCC_TN_RAZZ;
      end else if (st_done && !st_fail_elec && st_fail_mem) begin
         go_n    = 3'h3;
      end else if (ev_reject) begin
         go_kind = SCC_TN_RAZZ;
      end else if (ev_exit) begin
         go_kind = SCC_TN_LONG;
      end else if (ev_enter) begin
         go_n    = 3'h3;
      end else if (!ev_decode) begin
         tone_go = 1'b0;
      end
   end

   // tone sequencer: n tones with gaps between
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tone_left_r <= 3'h0;
         tone_tmr_r  <= 32'h0;
         tone_ph_r   <= 1'b0;
         tone_kind_r <= SCC_TN_BEEP;
      end else if (tone_go) begin
         tone_left_r <= go_n;
         tone_ph_r   <= 1'b1;
         tone_kind_r <= go_kind;
         tone_tmr_r  <= tone_len(go_kind) - 1;
      end else if (tone_tmr_r != 32'h0) begin
         tone_tmr_r <= tone_tmr_r - 32'h1;
      end else if (tone_ph_r) begin
         tone_ph_r   <= 1'b0;
         tone_left_r <= tone_left_r - 3'h1;
         tone_tmr_r  <= GAP_CYC - 1;
      end else if (tone_left_r != 3'h0) begin
         tone_ph_r  <= 1'b1;
         tone_tmr_r <= tone_len(tone_kind_r) - 1;
      end
   end

   // continuous razz for an electronics fault
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tone_cont_r <= 1'b0;
      end else if (st_done) begin
         tone_cont_r <= st_fail_elec;
      end
   end
   assign tone_on   = tone_ph_r | tone_cont_r;
   assign tone_razz = (tone_ph_r && tone_kind_r == SCC_TN_RAZZ) |
                      tone_cont_r;

   // =====================================================================
   // blink clock and single red flash timer
   always_ff @(posedge clk_sys) begin
      if (srst || blink_cnt_r == 32'h0) begin
         blink_cnt_r <= BLINK_CYC - 1;
         blink_r     <= srst ? 1'b0 : !blink_r;
      end else begin
         blink_cnt_r <= blink_cnt_r - 32'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flash_r <= 32'h0;
      end else if (ev_decode) begin
         flash_r <= FLASH_CYC;
      end else if (flash_r != 32'h0) begin
         flash_r <= flash_r - 32'h1;
      end
   end

   // led patterns, electronics, motor and laser faults first, then program mode, then normal
   always_comb begin
      unique case (fault_r)
         SCC_FLT_ELEC: begin
            led_green = 1'b0;
            led_red   = 1'b0;
         end
         SCC_FLT_LASER: begin
            led_green = blink_r;
            led_red   = 1'b0;
         end
         SCC_FLT_MOTOR: begin
            led_green = blink_r;
            led_red   = blink_r;
         end
         default: begin
            led_green = prog_r | laser_on;
            led_red   = prog_r ? blink_r :
                        (flash_r != 32'h0) | host_busy;
         end
      endcase
   end

   // =====================================================================
   // checks
   sequence s_frame_done;
      frame_end && frame_ok;
   endsequence

   sequence s_reply(logic [7:0] b);
      tx_valid && tx_data == b;
   endsequence

   a_ack_valid: assert property (@(posedge clk_sys) disable iff (srst)
      s_frame_done ##0 prog_r |=> s_reply(`SCC_ACK))
      else $error("valid command not acked");
   a_nak_invalid: assert property (@(posedge clk_sys) disable iff (srst)
      frame_end && !frame_ok |=> s_reply(`SCC_NAK) and !prog_r)
      else $error("invalid command not refused");
   a_enter_prog: assert property (@(posedge clk_sys) disable iff (srst)
      s_frame_done ##0 is_prog && !prog_r |=>
      prog_r and s_reply(`SCC_ACK))
      else $error("program mode not entered");
   a_exit_prog: assert property (@(posedge clk_sys) disable iff (srst)
      s_frame_done ##0 is_prog && prog_r |=>
      !prog_r && tone_on && tone_kind_r == SCC_TN_LONG)
      else $error("exit without long beep");
   a_timeout_nak: assert property (@(posedge clk_sys) disable iff (srst)
      tmo_hit |=> s_reply(`SCC_NAK) and !prog_r)
      else $error("timeout not answered");
   a_fmt_held: assert property (@(posedge clk_sys) disable iff (srst)
      prog_r && !ev_exit |=> $stable(ser_baud) && $stable(ser_par))
      else $error("format changed inside program mode");
   a_decode_off: assert property (@(posedge clk_sys) disable iff (srst)
      prog_r |-> !decode_en && scan_run)
      else $error("decoding in program mode");
   a_stx_clear: assert property (@(posedge clk_sys) disable iff (srst)
      q_pop && q_data == `SCC_STX |=>
      state_r == SCC_BODY && len_r == 3'h0 && !bad_r)
      else $error("start byte did not clear frame");
   a_red_hold: assert property (@(posedge clk_sys) disable iff (srst)
      fault_r == SCC_FLT_NONE && !prog_r && host_busy |-> led_red)
      else $error("red not held for busy host");
   a_tx_hold: assert property (@(posedge clk_sys) disable iff (srst)
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply dropped before taken");
endmodule : scc_cmd_interp

// *** logic/scc_regs.svh ***
// constants of the serial configuration command interpreter
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
// =====================================================================
// framing and reply bytes
`define SCC_STX        8'h02
`define SCC_ETX        8'h03
`define SCC_ACK        8'h06
`define SCC_NAK        8'h15
`define SCC_DIG_LO     8'h30
`define SCC_DIG_HI     8'h39
// =====================================================================
// special codes, six digits packed four bits per digit
`define SCC_MAX_DIG    6
`define SCC_CODE_PROG  24'h999999
`define SCC_CODE_DEFL  24'h999998
// =====================================================================
// factory serial format
`define SCC_DEF_BAUD   17'd9600
`define SCC_DEF_PAR    3'h4
`define SCC_DEF_STOP   2'h2
`define SCC_DEF_DATA   4'h7
// =====================================================================
// timing, figures in ms, counts at the 50 MHz system clock
`define SCC_CLK_KHZ    50000
`define SCC_TMO_MS     20000
`define SCC_BEEP_MS    100
`define SCC_LONG_MS    600
`define SCC_GAP_MS     100
`define SCC_BLINK_MS   250
`define SCC_FLASH_MS   150
`define SCC_TMO_CYC    (`SCC_TMO_MS * `SCC_CLK_KHZ)
`define SCC_BEEP_CYC   (`SCC_BEEP_MS * `SCC_CLK_KHZ)
`define SCC_LONG_CYC   (`SCC_LONG_MS * `SCC_CLK_KHZ)
`define SCC_GAP_CYC    (`SCC_GAP_MS * `SCC_CLK_KHZ)
`define SCC_BLINK_CYC  (`SCC_BLINK_MS * `SCC_CLK_KHZ)
`define SCC_FLASH_CYC  (`SCC_FLASH_MS * `SCC_CLK_KHZ)
`endif

// *** logic/scc_pkg.sv ***
// types of the serial configuration command interpreter
package scc_pkg;
   // =====================================================================
   // frame parser states
   typedef enum logic [1:0] {SCC_HUNT, SCC_BODY} scc_state_e;
   // tone kinds
   typedef enum logic [1:0] {SCC_TN_BEEP, SCC_TN_LONG, SCC_TN_RAZZ}
      scc_tone_e;
   // self-test outcome
   typedef enum logic [2:0] {SCC_FLT_NONE, SCC_FLT_MEM, SCC_FLT_LASER,
      SCC_FLT_MOTOR, SCC_FLT_ELEC} scc_fault_e;
   // parity codes of the serial format
   typedef enum logic [2:0] {SCC_PAR_NONE, SCC_PAR_ODD, SCC_PAR_EVEN,
      SCC_PAR_MARK, SCC_PAR_SPACE} scc_parity_e;
endpackage : scc_pkg

// *** logic/scc_rx_fifo.sv ***
// receive byte fifo with valid and ready on both sides
`timescale 1ns/10ps
module scc_rx_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             srst,
   // filling side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // draining side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   // =====================================================================
   // handshake
   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_r[rd_ptr_r];

   // storage, written only on a push
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and fill count, wrap at depth
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : scc_rx_fifo

// *** bench/scc_host_model.sv ***
// host model sending framed commands and taking replies
`timescale 1ns/10ps
`include "scc_regs.svh"
module scc_host_model (
   // byte link to the interpreter
   input  wire logic       clk_sys,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   input  wire logic       rx_ready,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready
);
   // =====================================================================
   // reply capture, stalled while hold is set
   logic       hold = 1'b0;
   logic [7:0] last_tx = 8'h00;
   int         n_tx = 0;
   int         refused = 0;
   initial rx_data = 8'h00;
   initial rx_valid = 1'b0;
   assign tx_ready = ~hold;
   always @(posedge clk_sys) begin
      if (tx_valid && tx_ready) begin
         last_tx <= tx_data;
         n_tx <= n_tx + 1;
      end
   end
   // offers one byte until taken or 20 cycles pass; valid stays up for the next byte
   task automatic put(input logic [7:0] b);
      int  i;
      logic ok;
      rx_data = b;
      rx_valid = 1'b1;
      ok = 1'b0;
      for (i = 0; i < 20 && !ok; i++) begin
         ok = (rx_ready === 1'b1);
         @(posedge clk_sys);
         #2;
      end
      if (!ok) refused++;
   endtask : put
   // drops the offer and shows the inverse of the last byte
   task automatic idle();
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask : idle
   // start byte, ascii payload, end byte
   task automatic frame(input string s);
      put(`SCC_STX);
      foreach (s[i]) put(s[i]);
      put(`SCC_ETX);
   endtask : frame
endmodule : scc_host_model

// *** bench/scc_cmd_interp_bench.sv ***
// self-checking bench of the command interpreter
`timescale 1ns/10ps
`include "scc_regs.svh"
module scc_cmd_interp_bench;
   import scc_pkg::*;
   // =====================================================================
   logic clk_sys = 1'b0, srst = 1'b1, fmt_wr = 1'b0, scan_req = 1'b0;
   logic laser_on = 1'b0, decode_ok = 1'b0, host_busy = 1'b0;
   logic st_done = 1'b0, st_fail_elec = 1'b0, seen_defl = 1'b0;
   logic [16:0] fmt_baud_in = 17'd0;
   logic [2:0] fmt_par_in = 3'h0;
   logic [1:0] fmt_stop_in = 2'h0;
   logic [3:0] fmt_data_in = 4'h0;
   logic st_fail_mem = 1'b0, st_fail_laser = 1'b0, st_fail_motor = 1'b0;
   logic [7:0] rx_data, tx_data;
   logic rx_valid, rx_ready, tx_valid, tx_ready, cfg_valid, cfg_defaults;
   logic [23:0] cfg_code;
   logic [2:0] cfg_len, ser_par;
   logic [16:0] ser_baud;
   logic [1:0] ser_stop;
   logic [3:0] ser_data;
   logic scan_run, decode_en, prog_mode, led_green, led_red;
   logic tone_on, tone_razz;
   int err_count = 0, comparisons = 0, n0;
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (cfg_defaults === 1'b1) seen_defl <= 1'b1;
   scc_host_model i_host (.clk_sys(clk_sys), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready));
   scc_cmd_interp #(.TMO_CYC(200), .BEEP_CYC(10), .LONG_CYC(30),
      .GAP_CYC(10), .BLINK_CYC(8), .FLASH_CYC(10)) i_scc_cmd_interp (
      .clk_sys(clk_sys), .srst(srst), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .cfg_code(cfg_code),
      .cfg_len(cfg_len), .cfg_valid(cfg_valid),
      .cfg_defaults(cfg_defaults), .fmt_wr(fmt_wr),
      .fmt_baud_in(fmt_baud_in), .fmt_par_in(fmt_par_in),
      .fmt_stop_in(fmt_stop_in), .fmt_data_in(fmt_data_in),
      .ser_baud(ser_baud), .ser_par(ser_par),
      .ser_stop(ser_stop), .ser_data(ser_data), .scan_req(scan_req),
      .laser_on(laser_on), .decode_ok(decode_ok), .host_busy(host_busy),
      .scan_run(scan_run), .decode_en(decode_en), .prog_mode(prog_mode),
      .st_done(st_done), .st_fail_mem(st_fail_mem),
      .st_fail_laser(st_fail_laser), .st_fail_motor(st_fail_motor),
      .st_fail_elec(st_fail_elec),
      .led_green(led_green), .led_red(led_red), .tone_on(tone_on),
      .tone_razz(tone_razz));
   // compare and count
   task automatic check(input string nm, input logic [23:0] e,
                        input logic [23:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   // bounded wait for one reply byte
   task automatic wait_reply(input int n, input logic [7:0] e, input int lim);
      int i;
      for (i = 0; i < lim && i_host.n_tx == n; i++) @(posedge clk_sys);
      #2;
      check("reply_count", 24'(n + 1), 24'(i_host.n_tx));
      check("reply", e, i_host.last_tx);
   endtask : wait_reply
   task automatic cmd(input string s, input logic [7:0] e);
      n0 = i_host.n_tx;
      i_host.frame(s);
      i_host.idle();
      wait_reply(n0, e, 40);
   endtask : cmd
   // one self-test report: {elec, motor, laser, mem}
   task automatic self_test(input logic [3:0] f);
      @(posedge clk_sys);
      #2 {st_fail_elec, st_fail_motor, st_fail_laser, st_fail_mem} = f;
      st_done = 1'b1;
      @(posedge clk_sys);
      #2 st_done = 1'b0;
      repeat (3) @(posedge clk_sys);
      #2;
   endtask : self_test
   // verdict and end of run
   task automatic complete_run;
      if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   initial begin
      #800000;
      err_count++;
      complete_run();
   end
   // main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      #2 srst = 1'b0;
      check("ser_baud", `SCC_DEF_BAUD, ser_baud);
      check("ser_fmt", {`SCC_DEF_PAR, `SCC_DEF_STOP, `SCC_DEF_DATA},
            {ser_par, ser_stop, ser_data});
      cmd("123456", `SCC_NAK);
      cmd("999999", `SCC_ACK);
      check("mode_run_dec", 3'b110, {prog_mode, scan_run, decode_en});
      check("prog_green", 1, led_green);
      cmd("999998", `SCC_ACK);
      check("cfg_defaults", 1, seen_defl);
      fmt_baud_in = 17'd19200;
      fmt_par_in = 3'h1;
      fmt_stop_in = 2'h1;
      fmt_data_in = 4'h8;
      fmt_wr = 1'b1;
      @(posedge clk_sys);
      #2 fmt_wr = 1'b0;
      cmd("7", `SCC_ACK);
      check("ser_baud_held", `SCC_DEF_BAUD, ser_baud);
      cmd("999999", `SCC_ACK);
      check("exit_tone", 2'b01, {prog_mode, tone_on});
      check("ser_baud_new", 17'd19200, ser_baud);
      check("ser_fmt_new", {3'h1, 2'h1, 4'h8}, {ser_par, ser_stop, ser_data});
      cmd("999999", `SCC_ACK);
      cmd("9999:", `SCC_NAK);
      check("razz", 3'b011, {prog_mode, tone_on, tone_razz});
      cmd("999998", `SCC_NAK);
      cmd("999999", `SCC_ACK);
      n0 = i_host.n_tx;
      wait_reply(n0, `SCC_NAK, 400);
      i_host.put(8'h39);
      i_host.put(`SCC_STX);
      i_host.put(8'h31);
      cmd("999999", `SCC_ACK);
      cmd("999999", `SCC_ACK);
      i_host.hold = 1'b1;
      n0 = i_host.n_tx;
      i_host.frame("1");
      repeat (9) i_host.put(8'h41);
      i_host.idle();
      check("fifo_refused", 1, i_host.refused != 0);
      i_host.hold = 1'b0;
      wait_reply(n0, `SCC_NAK, 40);
      laser_on = 1'b1;
      scan_req = 1'b1;
      #1 check("led_green", 1, led_green);
      check("scan_idle", 2'b11, {scan_run, decode_en});
      @(posedge clk_sys);
      #2 decode_ok = 1'b1;
      @(posedge clk_sys);
      #2 decode_ok = 1'b0;
      @(posedge clk_sys);
      #2 check("red_tone", 2'b11, {led_red, tone_on});
      repeat (20) @(posedge clk_sys);
      #2 check("red_off", 2'b00, {led_red, tone_on});
      host_busy = 1'b1;
      #1 check("red_busy", 1, led_red);
      self_test(4'b1000);
      check("elec_fault", 4'b0011, {led_green, led_red, tone_on,
            tone_razz});
      self_test(4'b0100);
      check("motor_fault", 3'b111, {tone_on, tone_razz,
            led_green == led_red});
      self_test(4'b0010);
      check("laser_fault", 3'b011, {led_red, tone_on, tone_razz});
      self_test(4'b0001);
      check("mem_fault", 4'b1110, {led_green, led_red, tone_on,
            tone_razz});
      complete_run();
   end
endmodule : scc_cmd_interp_bench
